// ### hw/tec_config.sv
// configuration register, trip thresholds and event pin of the sensor
`timescale 1ns/1ps
`default_nettype none
module tec_config (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic [tec_pkg::SEL_W-1:0]   reg_sel_i,
  input  wire logic                        reg_wr_i,
  input  wire logic [tec_pkg::DATA_W-1:0]  reg_wdata_i,
  output logic      [tec_pkg::DATA_W-1:0]  reg_rdata_o,
  input  wire logic                        temp_valid_i,
  input  wire logic [tec_pkg::TEMP_W-1:0]  temp_i,
  output logic                             shdn_o,
  output logic                             event_pin_o,
  output logic                             crit_trip_o,
  output logic                             above_trip_o,
  output logic                             below_trip_o
);
  logic [tec_pkg::CTRL_W-1:0]   ctrl_q;
  logic [tec_pkg::CTRL_W-1:0]   ctrl_d;
  logic                         alock_q;
  logic                         alock_d;
  logic                         clock_q;
  logic                         clock_d;
  logic                         shdn_d;
  logic [1:0]                   hyst_q;
  logic [1:0]                   hyst_d;
  logic [tec_pkg::THR_W-1:0]    upper_q;
  logic [tec_pkg::THR_W-1:0]    upper_d;
  logic [tec_pkg::THR_W-1:0]    lower_q;
  logic [tec_pkg::THR_W-1:0]    lower_d;
  logic [tec_pkg::THR_W-1:0]    crit_q;
  logic [tec_pkg::THR_W-1:0]    crit_d;
  logic [tec_pkg::DATA_W-1:0]   rdata_d;
  logic [tec_pkg::DATA_W-1:0]   cfg_word;
  logic [tec_pkg::THR_W-1:0]    wthr;
  logic [tec_pkg::TEMP_W-1:0]   upper_t;
  logic [tec_pkg::TEMP_W-1:0]   lower_t;
  logic [tec_pkg::TEMP_W-1:0]   crit_t;
  logic [tec_pkg::HYST_W-1:0]   hyst_steps;
  logic                         wr_cfg;
  logic                         wr_upper;
  logic                         wr_lower;
  logic                         wr_crit;
  logic                         locked;
  logic                         clear_req;
  logic                         active;

  // decode
  assign wr_cfg   = reg_wr_i && (reg_sel_i == tec_pkg::SEL_CONFIG);
  assign wr_upper = reg_wr_i && (reg_sel_i == tec_pkg::SEL_UPPER);
  assign wr_lower = reg_wr_i && (reg_sel_i == tec_pkg::SEL_LOWER);
  assign wr_crit  = reg_wr_i && (reg_sel_i == tec_pkg::SEL_CRIT);
  assign locked   = alock_q || clock_q;
  assign wthr     = reg_wdata_i[tec_pkg::THR_HI:tec_pkg::THR_LO];

  // configuration next state
  assign ctrl_d  = (wr_cfg && !locked) ?
                   reg_wdata_i[tec_pkg::CTRL_W-1:0] : ctrl_q;
  assign alock_d = alock_q ||
                   (wr_cfg && reg_wdata_i[tec_pkg::B_ALARM_LOCK]);
  assign clock_d = clock_q ||
                   (wr_cfg && reg_wdata_i[tec_pkg::B_CRIT_LOCK]);
  assign shdn_d  = !wr_cfg ? shdn_o :
                   !reg_wdata_i[tec_pkg::B_SHDN] ? 1'b0 :
                   locked ? shdn_o : 1'b1;
  assign hyst_d  = wr_cfg ?
                   reg_wdata_i[tec_pkg::B_HYST_HI:tec_pkg::B_HYST_LO] :
                   hyst_q;
  assign clear_req = wr_cfg && reg_wdata_i[tec_pkg::B_CLEAR];

  // thresholds
  assign upper_d = (wr_upper && !alock_q) ? wthr : upper_q;
  assign lower_d = (wr_lower && !alock_q) ? wthr : lower_q;
  assign crit_d  = (wr_crit && !clock_q) ? wthr : crit_q;
  assign upper_t = {upper_q, 2'b00};
  assign lower_t = {lower_q, 2'b00};
  assign crit_t  = {crit_q, 2'b00};

  assign hyst_steps = (hyst_q == tec_pkg::HYST_OFF) ? tec_pkg::HSTEP_OFF :
                      (hyst_q == tec_pkg::HYST_1P5) ? tec_pkg::HSTEP_1P5 :
                      (hyst_q == tec_pkg::HYST_3)   ? tec_pkg::HSTEP_3 :
                                                      tec_pkg::HSTEP_6;

  // readback; clear bit and reserved bits read 0
  assign cfg_word = {{(tec_pkg::DATA_W-tec_pkg::B_RSVD_LO){1'b0}}, hyst_q,
                     shdn_o, clock_q, alock_q, 1'b0, active,
                     ctrl_q};
  assign rdata_d =
    (reg_sel_i == tec_pkg::SEL_CONFIG) ? cfg_word :
    (reg_sel_i == tec_pkg::SEL_UPPER)  ? {3'h0, upper_q, 2'h0} :
    (reg_sel_i == tec_pkg::SEL_LOWER)  ? {3'h0, lower_q, 2'h0} :
    (reg_sel_i == tec_pkg::SEL_CRIT)   ? {3'h0, crit_q, 2'h0} :
                                          tec_pkg::CFG_RESET;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q      <= tec_pkg::CTRL_RESET;
      alock_q     <= 1'b0;
      clock_q     <= 1'b0;
      shdn_o      <= 1'b0;
      hyst_q      <= tec_pkg::HYST_RESET;
      upper_q     <= '0;
      lower_q     <= '0;
      crit_q      <= '0;
      reg_rdata_o <= tec_pkg::CFG_RESET;
    end
    else
    begin
      ctrl_q      <= ctrl_d;
      alock_q     <= alock_d;
      clock_q     <= clock_d;
      shdn_o      <= shdn_d;
      hyst_q      <= hyst_d;
      upper_q     <= upper_d;
      lower_q     <= lower_d;
      crit_q      <= crit_d;
      reg_rdata_o <= rdata_d;
    end
  end

  // trip comparators
  tec_trip_cmp #(.KIND(tec_pkg::TEC_CMP_ABOVE)) u_above (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .sample_i (temp_valid_i),
    .shdn_i   (shdn_o),
    .temp_i   (temp_i),
    .thr_i    (upper_t),
    .hyst_i   (hyst_steps),
    .trip_o   (above_trip_o)
  );

  tec_trip_cmp #(.KIND(tec_pkg::TEC_CMP_BELOW)) u_below (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .sample_i (temp_valid_i),
    .shdn_i   (shdn_o),
    .temp_i   (temp_i),
    .thr_i    (lower_t),
    .hyst_i   (hyst_steps),
    .trip_o   (below_trip_o)
  );

  tec_trip_cmp #(.KIND(tec_pkg::TEC_CMP_CRIT)) u_crit (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .sample_i (temp_valid_i),
    .shdn_i   (shdn_o),
    .temp_i   (temp_i),
    .thr_i    (crit_t),
    .hyst_i   (hyst_steps),
    .trip_o   (crit_trip_o)
  );

  tec_event_ctl u_event (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .mode_irq_i  (ctrl_q[tec_pkg::B_MODE]),
    .pol_high_i  (ctrl_q[tec_pkg::B_POL]),
    .crit_only_i (ctrl_q[tec_pkg::B_CRIT_ONLY]),
    .out_en_i    (ctrl_q[tec_pkg::B_OUT_EN]),
    .shdn_i      (shdn_o),
    .alarm_i     (above_trip_o || below_trip_o),
    .crit_i      (crit_trip_o),
    .clear_i     (clear_req),
    .active_o    (active),
    .pin_o       (event_pin_o)
  );

  // checks
  property p_lock_ctrl;
    @(posedge clk_i) disable iff (rst_i)
    (wr_cfg && locked) |=> $stable(ctrl_q);
  endproperty
  a_lock_ctrl: assert property (p_lock_ctrl)
    else $error("control bits changed while locked");

  property p_lock_sticky;
    @(posedge clk_i) disable iff (rst_i)
    alock_q |=> alock_q;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky)
    else $error("alarm lock cleared without reset");

  property p_lock_single;
    @(posedge clk_i) disable iff (rst_i)
    (wr_cfg && reg_wdata_i[tec_pkg::B_CRIT_LOCK]) |=> clock_q;
  endproperty
  a_lock_single: assert property (p_lock_single)
    else $error("critical lock not set by one write");

  property p_alarm_thr_lock;
    @(posedge clk_i) disable iff (rst_i)
    (alock_q && (wr_upper || wr_lower)) |=> ($stable(upper_q) && $stable(lower_q));
  endproperty
  a_alarm_thr_lock: assert property (p_alarm_thr_lock)
    else $error("alarm threshold changed while locked");

  property p_crit_thr_lock;
    @(posedge clk_i) disable iff (rst_i)
    (clock_q && wr_crit) |=> $stable(crit_q);
  endproperty
  a_crit_thr_lock: assert property (p_crit_thr_lock)
    else $error("critical threshold changed while locked");

  property p_shdn_set_refused;
    @(posedge clk_i) disable iff (rst_i)
    (wr_cfg && locked && !shdn_o) |=> !shdn_o;
  endproperty
  a_shdn_set_refused: assert property (p_shdn_set_refused)
    else $error("shutdown set while locked");

  property p_shdn_clear;
    @(posedge clk_i) disable iff (rst_i)
    (wr_cfg && !reg_wdata_i[tec_pkg::B_SHDN]) |=> !shdn_o;
  endproperty
  a_shdn_clear: assert property (p_shdn_clear)
    else $error("shutdown clear refused");

  sequence s_cfg_read;
    (reg_sel_i == tec_pkg::SEL_CONFIG) && !reg_wr_i;
  endsequence
  property p_read_zero_bits;
    @(posedge clk_i) disable iff (rst_i)
    s_cfg_read |=> (reg_rdata_o[tec_pkg::B_CLEAR] == 1'b0) &&
                   (reg_rdata_o[tec_pkg::DATA_W-1:tec_pkg::B_RSVD_LO] == 5'h00);
  endproperty
  a_read_zero_bits: assert property (p_read_zero_bits)
    else $error("clear or reserved bit read nonzero");

  property p_status_read;
    @(posedge clk_i) disable iff (rst_i)
    s_cfg_read |=> (reg_rdata_o[tec_pkg::B_STATUS] == $past(active));
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status bit differs from event state");

  property p_disabled_quiet;
    @(posedge clk_i) disable iff (rst_i)
    (!ctrl_q[tec_pkg::B_OUT_EN] && !ctrl_d[tec_pkg::B_OUT_EN]) |=> !active;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("event asserted while output disabled");

  property p_pin_level;
    @(posedge clk_i) disable iff (rst_i)
    ##1 $stable(ctrl_q[tec_pkg::B_POL]) |->
      (event_pin_o == (ctrl_q[tec_pkg::B_POL] ? active : !active));
  endproperty
  a_pin_level: assert property (p_pin_level)
    else $error("event pin polarity wrong");

  property p_crit_no_clear;
    @(posedge clk_i) disable iff (rst_i)
    (active && crit_trip_o && ctrl_q[tec_pkg::B_MODE] && !shdn_o &&
     $stable(ctrl_q[tec_pkg::B_MODE]) &&
     ctrl_q[tec_pkg::B_OUT_EN] && clear_req) |=> active;
  endproperty
  a_crit_no_clear: assert property (p_crit_no_clear)
    else $error("event cleared while critical");

  property p_shdn_no_event;
    @(posedge clk_i) disable iff (rst_i)
    shdn_o [*2] |=> !crit_trip_o && !above_trip_o && !below_trip_o;
  endproperty
  a_shdn_no_event: assert property (p_shdn_no_event)
    else $error("trip flag set during shutdown");

  sequence s_cmp_crit;
    !ctrl_q[tec_pkg::B_MODE] && ctrl_q[tec_pkg::B_OUT_EN] && !shdn_o &&
    crit_trip_o;
  endsequence
  property p_cmp_follow;
    @(posedge clk_i) disable iff (rst_i)
    s_cmp_crit |=> active;
  endproperty
  a_cmp_follow: assert property (p_cmp_follow)
    else $error("comparator event missing at critical");

  property p_cmp_idle;
    @(posedge clk_i) disable iff (rst_i)
    (!ctrl_q[tec_pkg::B_MODE] && !crit_trip_o && !above_trip_o &&
     !below_trip_o) |=> !active;
  endproperty
  a_cmp_idle: assert property (p_cmp_idle)
    else $error("comparator event without trip");

  sequence s_clear_steady;
    clear_req && ctrl_q[tec_pkg::B_MODE] && !crit_trip_o &&
    $stable(crit_trip_o) && $stable(above_trip_o) &&
    $stable(below_trip_o) && $stable(ctrl_q) && $stable(shdn_o);
  endsequence
  property p_irq_clear;
    @(posedge clk_i) disable iff (rst_i)
    s_clear_steady |=> !active;
  endproperty
  a_irq_clear: assert property (p_irq_clear)
    else $error("pending event not cleared");
endmodule // tec_config
`default_nettype wire

// ### hw/tec_event_ctl.sv
// event pin control: comparator or latched interrupt operation
`timescale 1ns/1ps
`default_nettype none
module tec_event_ctl (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic mode_irq_i,
  input  wire logic pol_high_i,
  input  wire logic crit_only_i,
  input  wire logic out_en_i,
  input  wire logic shdn_i,
  input  wire logic alarm_i,
  input  wire logic crit_i,
  input  wire logic clear_i,
  output logic      active_o,
  output logic      pin_o
);
  logic trip_c;
  logic trip_prev_q;
  logic rise_c;
  logic clear_ok_c;
  logic latch_q;
  logic latch_d;
  logic active_d;

  assign trip_c = !shdn_i && (crit_i || (!crit_only_i && alarm_i));
  assign rise_c = trip_c && !trip_prev_q;
  assign clear_ok_c = clear_i && mode_irq_i && !crit_i;
  // latch only runs in interrupt operation, no stale event on mode change
  assign latch_d = !mode_irq_i ? 1'b0 :
                   rise_c ? 1'b1 :
                   (clear_ok_c || shdn_i) ? 1'b0 : latch_q;
  assign active_d = out_en_i && (mode_irq_i ? latch_d : trip_c);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      trip_prev_q <= 1'b0;
      latch_q     <= 1'b0;
      active_o    <= 1'b0;
      pin_o       <= 1'b1;
    end
    else
    begin
      trip_prev_q <= trip_c;
      latch_q     <= latch_d;
      active_o    <= active_d;
      pin_o       <= pol_high_i ? active_d : !active_d;
    end
  end
endmodule // tec_event_ctl
`default_nettype wire

// ### hw/tec_pkg.sv
// constants and field layout for the thermal event configuration block
`default_nettype none
package tec_pkg;
  localparam int unsigned DATA_W       = 16;
  localparam int unsigned TEMP_W       = 13;
  localparam int unsigned SEL_W        = 3;
  localparam int unsigned HYST_W       = 7;

  // register pointer values
  localparam logic [2:0]  SEL_CONFIG   = 3'h1;
  localparam logic [2:0]  SEL_UPPER    = 3'h2;
  localparam logic [2:0]  SEL_LOWER    = 3'h3;
  localparam logic [2:0]  SEL_CRIT     = 3'h4;

  // configuration word bit positions
  localparam int unsigned B_MODE       = 0;
  localparam int unsigned B_POL        = 1;
  localparam int unsigned B_CRIT_ONLY  = 2;
  localparam int unsigned B_OUT_EN     = 3;
  localparam int unsigned B_STATUS     = 4;
  localparam int unsigned B_CLEAR      = 5;
  localparam int unsigned B_ALARM_LOCK = 6;
  localparam int unsigned B_CRIT_LOCK  = 7;
  localparam int unsigned B_SHDN       = 8;
  localparam int unsigned B_HYST_LO    = 9;
  localparam int unsigned B_HYST_HI    = 10;
  localparam int unsigned B_RSVD_LO    = 11;
  localparam int unsigned CTRL_W       = 4;

  // threshold layout: value in bits 12:2, low two bits and top three read 0
  localparam int unsigned THR_HI       = 12;
  localparam int unsigned THR_LO       = 2;
  localparam int unsigned THR_W        = THR_HI - THR_LO + 1;

  localparam logic [15:0] CFG_RESET    = 16'h0000;
  localparam logic [15:0] THR_RESET    = 16'h0000;
  localparam logic [3:0]  CTRL_RESET   = 4'h0;
  localparam logic [1:0]  HYST_RESET   = 2'h0;

  // hysteresis in sensor steps of 1/16 degree
  localparam logic [1:0]  HYST_OFF     = 2'h0;
  localparam logic [1:0]  HYST_1P5     = 2'h1;
  localparam logic [1:0]  HYST_3       = 2'h2;
  localparam logic [6:0]  HSTEP_OFF    = 7'h00;
  localparam logic [6:0]  HSTEP_1P5    = 7'h18;
  localparam logic [6:0]  HSTEP_3      = 7'h30;
  localparam logic [6:0]  HSTEP_6      = 7'h60;

  typedef enum logic [1:0] {
    TEC_CMP_ABOVE,
    TEC_CMP_BELOW,
    TEC_CMP_CRIT
  } tec_cmp_e;
endpackage : tec_pkg
`default_nettype wire

// ### hw/tec_trip_cmp.sv
// one trip comparison with hysteresis on release
`timescale 1ns/1ps
`default_nettype none
module tec_trip_cmp #(
  parameter tec_pkg::tec_cmp_e KIND = tec_pkg::TEC_CMP_ABOVE
) (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        sample_i,
  input  wire logic                        shdn_i,
  input  wire logic [tec_pkg::TEMP_W-1:0]  temp_i,
  input  wire logic [tec_pkg::TEMP_W-1:0]  thr_i,
  input  wire logic [tec_pkg::HYST_W-1:0]  hyst_i,
  output logic                             trip_o
);
  logic signed [tec_pkg::TEMP_W:0] temp_s;
  logic signed [tec_pkg::TEMP_W:0] thr_s;
  logic signed [tec_pkg::TEMP_W:0] hyst_s;
  logic signed [tec_pkg::TEMP_W:0] thr_dn;
  logic signed [tec_pkg::TEMP_W:0] thr_up;
  logic                            set_c;
  logic                            rel_c;
  logic                            trip_d;

  assign temp_s = {temp_i[tec_pkg::TEMP_W-1], temp_i};
  assign thr_s  = {thr_i[tec_pkg::TEMP_W-1], thr_i};
  assign hyst_s = {{(tec_pkg::TEMP_W+1-tec_pkg::HYST_W){1'b0}}, hyst_i};
  assign thr_dn = thr_s - hyst_s;
  assign thr_up = thr_s + hyst_s;

  // critical is equal-or-above, alarm limits are strict
  assign set_c = (KIND == tec_pkg::TEC_CMP_CRIT)  ? (temp_s >= thr_s) :
                 (KIND == tec_pkg::TEC_CMP_BELOW) ? (temp_s <  thr_s) :
                                                    (temp_s >  thr_s);
  assign rel_c = (KIND == tec_pkg::TEC_CMP_CRIT)  ? (temp_s <  thr_dn) :
                 (KIND == tec_pkg::TEC_CMP_BELOW) ? (temp_s >= thr_up) :
                                                    (temp_s <= thr_dn);
  assign trip_d = shdn_i ? 1'b0 :
                  !sample_i ? trip_o :
                  set_c ? 1'b1 :
                  rel_c ? 1'b0 : trip_o;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      trip_o <= 1'b0;
    end
    else
    begin
      trip_o <= trip_d;
    end
  end
endmodule // tec_trip_cmp
`default_nettype wire

// ### test/tec_host_model.sv
// host side model driving the register port of the event block
`timescale 1ns/1ps
`default_nettype none
module tec_host_model (
  input  wire logic                        clk_i,
  input  wire logic [tec_pkg::DATA_W-1:0]  rdata_i,
  output logic      [tec_pkg::SEL_W-1:0]   sel_o,
  output logic                             wr_o,
  output logic      [tec_pkg::DATA_W-1:0]  wdata_o
);
  initial
  begin
    sel_o   = 3'h0;
    wr_o    = 1'b0;
    wdata_o = 16'h0000;
  end

  // one-cycle write strobe, data held with it
  task automatic wr(input logic [2:0] s, input logic [15:0] d);
    @(posedge clk_i);
    #1;
    sel_o   = s;
    wdata_o = d;
    wr_o    = 1'b1;
    @(posedge clk_i);
    #1;
    wr_o    = 1'b0;
  endtask

  // readback is registered, so wait two edges
  task automatic rd(input logic [2:0] s, output logic [15:0] d);
    @(posedge clk_i);
    #1;
    sel_o = s;
    @(posedge clk_i);
    @(posedge clk_i);
    #1;
    d = rdata_i;
  endtask
endmodule // tec_host_model
`default_nettype wire

// ### test/testbench.sv
// self-checking bench for the configuration and event block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed
  {
    logic [2:0]  sel;
    logic [15:0] wd;
    logic [15:0] exp;
  } tec_row_s;

  logic        clk_i        = 1'b0;
  logic        rst_i        = 1'b1;
  logic        temp_valid_i = 1'b0;
  logic [12:0] temp_i       = 13'h0000;
  logic [2:0]  reg_sel_i;
  logic        reg_wr_i;
  logic [15:0] reg_wdata_i;
  logic [15:0] reg_rdata_o;
  logic [15:0] got;
  logic        shdn_o;
  logic        event_pin_o;
  logic        crit_trip_o;
  logic        above_trip_o;
  logic        below_trip_o;
  int          n_mismatch   = 0;
  int          checks       = 0;
  tec_row_s    rows [13]    = '{
    '{3'h1, 16'h0001, 16'h0001}, '{3'h1, 16'h0002, 16'h0002},
    '{3'h1, 16'h0004, 16'h0004}, '{3'h1, 16'h0028, 16'h0008},
    '{3'h1, 16'hF810, 16'h0000}, '{3'h1, 16'h0200, 16'h0200},
    '{3'h1, 16'h0400, 16'h0400}, '{3'h1, 16'h0600, 16'h0600},
    '{3'h2, 16'hFFFF, 16'h1FFC}, '{3'h3, 16'h0043, 16'h0040},
    '{3'h4, 16'h0101, 16'h0100}, '{3'h5, 16'h1234, 16'h0000},
    '{3'h1, 16'h0000, 16'h0000}};

  always #10 clk_i = ~clk_i;

  tec_host_model tec_host_model_i (
    .clk_i   (clk_i),
    .rdata_i (reg_rdata_o),
    .sel_o   (reg_sel_i),
    .wr_o    (reg_wr_i),
    .wdata_o (reg_wdata_i)
  );

  tec_config tec_config_i (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .reg_sel_i    (reg_sel_i),
    .reg_wr_i     (reg_wr_i),
    .reg_wdata_i  (reg_wdata_i),
    .reg_rdata_o  (reg_rdata_o),
    .temp_valid_i (temp_valid_i),
    .temp_i       (temp_i),
    .shdn_o       (shdn_o),
    .event_pin_o  (event_pin_o),
    .crit_trip_o  (crit_trip_o),
    .above_trip_o (above_trip_o),
    .below_trip_o (below_trip_o)
  );

  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %0t word %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %0t flag %b expected %b", $time, g, e);
    end
  endtask

  // one sample, then wait until the pin has followed
  task automatic samp(input logic [12:0] t);
    @(posedge clk_i);
    #1;
    temp_i       = t;
    temp_valid_i = 1'b1;
    @(posedge clk_i);
    #1;
    temp_valid_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  task automatic cfg(input logic [15:0] d);
    tec_host_model_i.wr(3'h1, d);
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  task automatic rdc(input logic [2:0] s, input logic [15:0] e);
    tec_host_model_i.rd(s, got);
    chk16(got, e);
  endtask

  task automatic test_done;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    #100000;
    n_mismatch++;
    test_done;
  end

  initial
  begin
    repeat (6) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    rdc(3'h1, 16'h0000);
    chk1(event_pin_o, 1'b1);
    $display("test reset done");
    foreach (rows[i])
    begin
      tec_host_model_i.wr(rows[i].sel, rows[i].wd);
      rdc(rows[i].sel, rows[i].exp);
    end
    $display("test table done");
    tec_host_model_i.wr(3'h2, 16'h00C0);
    tec_host_model_i.wr(3'h3, 16'h0040);
    tec_host_model_i.wr(3'h4, 16'h0100);
    samp(13'h00D0);
    chk1(above_trip_o, 1'b1);
    chk1(event_pin_o, 1'b1);
    cfg(16'h0008);
    samp(13'h0080);
    chk1(event_pin_o, 1'b1);
    samp(13'h0030);
    chk1(below_trip_o, 1'b1);
    chk1(event_pin_o, 1'b0);
    samp(13'h00D0);
    chk1(event_pin_o, 1'b0);
    rdc(3'h1, 16'h0018);
    cfg(16'h0028);
    chk1(event_pin_o, 1'b0);
    samp(13'h0080);
    chk1(event_pin_o, 1'b1);
    samp(13'h0100);
    chk1(crit_trip_o, 1'b1);
    cfg(16'h000A);
    chk1(event_pin_o, 1'b1);
    cfg(16'h000C);
    samp(13'h00D0);
    chk1(event_pin_o, 1'b1);
    samp(13'h0110);
    chk1(event_pin_o, 1'b0);
    $display("test comparator done");
    cfg(16'h0009);
    samp(13'h0080);
    samp(13'h00D0);
    samp(13'h0080);
    chk1(event_pin_o, 1'b0);
    cfg(16'h0009);
    chk1(event_pin_o, 1'b0);
    cfg(16'h0029);
    chk1(event_pin_o, 1'b1);
    samp(13'h0110);
    cfg(16'h0029);
    chk1(event_pin_o, 1'b0);
    samp(13'h0080);
    cfg(16'h0029);
    chk1(event_pin_o, 1'b1);
    $display("test interrupt done");
    cfg(16'h0208);
    samp(13'h00D0);
    chk1(event_pin_o, 1'b0);
    samp(13'h00B0);
    chk1(above_trip_o, 1'b1);
    samp(13'h00A8);
    chk1(above_trip_o, 1'b0);
    cfg(16'h0608);
    samp(13'h00D0);
    samp(13'h0068);
    chk1(above_trip_o, 1'b1);
    samp(13'h0060);
    chk1(above_trip_o, 1'b0);
    samp(13'h0030);
    samp(13'h0090);
    chk1(below_trip_o, 1'b1);
    chk1(event_pin_o, 1'b0);
    samp(13'h00A0);
    chk1(below_trip_o, 1'b0);
    $display("test hysteresis done");
    cfg(16'h0108);
    chk1(shdn_o, 1'b1);
    samp(13'h0110);
    chk1(crit_trip_o, 1'b0);
    chk1(event_pin_o, 1'b1);
    cfg(16'h0148);
    rdc(3'h1, 16'h0148);
    cfg(16'h0048);
    chk1(shdn_o, 1'b0);
    cfg(16'h0143);
    rdc(3'h1, 16'h0048);
    tec_host_model_i.wr(3'h2, 16'h0200);
    rdc(3'h2, 16'h00C0);
    tec_host_model_i.wr(3'h4, 16'h0180);
    rdc(3'h4, 16'h0180);
    cfg(16'h00C8);
    tec_host_model_i.wr(3'h4, 16'h0200);
    rdc(3'h4, 16'h0180);
    cfg(16'h0000);
    rdc(3'h1, 16'h00C8);
    $display("test locks done");
    rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    rdc(3'h1, 16'h0000);
    chk1(event_pin_o, 1'b1);
    tec_host_model_i.wr(3'h4, 16'h0200);
    rdc(3'h4, 16'h0200);
    $display("test reset again done");
    test_done;
  end
endmodule // testbench
`default_nettype wire
